// ---- rtl/fdq_pkg.sv ----
// constants, types and opcode encodings for the dual quad flash command decoder
// assumes both dies see the same chip select and serial clock from the host
package fdq_pkg;

   localparam int NUM_DIES = 2;
   localparam int LANES_PER_DIE = 4;

   // bank register layout and reset value
   localparam int         BANK_EXT_BIT   = 7;
   localparam int         BANK_SEL_MSB   = 1;
   localparam logic [7:0] BANK_RESET_VAL = 8'h00;

   localparam logic [5:0] ADDR_BITS_A24 = 6'h18;
   localparam logic [5:0] ADDR_BITS_A32 = 6'h20;
   localparam logic [2:0] INSTR_LAST_BIT = 3'h7;

   localparam logic [7:0] OP_FAST_READ_A32       = 8'h0c;
   localparam logic [7:0] OP_PLAIN_READ_A32      = 8'h13;
   localparam logic [7:0] OP_QUAD_OUT_READ_A32   = 8'h6c;
   localparam logic [7:0] OP_QUAD_IO_READ_A32    = 8'hec;
   localparam logic [7:0] OP_DDR_QUAD_IO_READ_A32 = 8'hee;
   localparam logic [7:0] OP_PAGE_PROG_A32       = 8'h12;
   localparam logic [7:0] OP_QUAD_PAGE_PROG_A32  = 8'h34;
   localparam logic [7:0] OP_SECTOR_ERASE_A32    = 8'hdc;
   localparam logic [7:0] OP_PLAIN_READ_LEGACY   = 8'h03;
   localparam logic [7:0] OP_FAST_READ_LEGACY    = 8'h0b;
   localparam logic [7:0] OP_QUAD_OUT_READ_LEGACY = 8'h6b;
   localparam logic [7:0] OP_QUAD_IO_READ_LEGACY = 8'heb;
   localparam logic [7:0] OP_DDR_QUAD_IO_READ_LEGACY = 8'hed;
   localparam logic [7:0] OP_PAGE_PROG_LEGACY    = 8'h02;
   localparam logic [7:0] OP_QUAD_PAGE_PROG_LEGACY = 8'h32;
   localparam logic [7:0] OP_SECTOR_ERASE_LEGACY = 8'hd8;
   localparam logic [7:0] OP_MAKER_SIGNATURE_READ = 8'h90;
   localparam logic [7:0] OP_IDENTIFIER_READ     = 8'h9f;
   localparam logic [7:0] OP_SIGNATURE_READ      = 8'hab;
   localparam logic [7:0] OP_PARAM_TABLE_READ    = 8'h5a;
   localparam logic [7:0] OP_STATUS1_READ        = 8'h05;
   localparam logic [7:0] OP_STATUS2_READ        = 8'h07;
   localparam logic [7:0] OP_CONFIG1_READ        = 8'h35;
   localparam logic [7:0] OP_REG_WRITE           = 8'h01;
   localparam logic [7:0] OP_WRITE_DISABLE       = 8'h04;
   localparam logic [7:0] OP_WRITE_ENABLE        = 8'h06;
   localparam logic [7:0] OP_FAIL_CLEAR          = 8'h30;
   localparam logic [7:0] OP_BOOT_REG_READ       = 8'h14;
   localparam logic [7:0] OP_BOOT_REG_WRITE      = 8'h15;
   localparam logic [7:0] OP_BANK_REG_READ       = 8'h16;
   localparam logic [7:0] OP_BANK_REG_WRITE      = 8'h17;
   localparam logic [7:0] OP_BANK_REG_LEGACY     = 8'hb9;
   localparam logic [7:0] OP_LEARN_PATTERN_READ  = 8'h41;
   localparam logic [7:0] OP_LEARN_PATTERN_NV_PROG = 8'h43;
   localparam logic [7:0] OP_LEARN_PATTERN_VOL_WRITE = 8'h4a;

   typedef enum logic [3:0] {
      FDQ_K_NONE      = 4'h0,
      FDQ_K_READ      = 4'h1,
      FDQ_K_PROG      = 4'h2,
      FDQ_K_ERASE     = 4'h3,
      FDQ_K_ID        = 4'h4,
      FDQ_K_REG_RD    = 4'h5,
      FDQ_K_REG_WR    = 4'h6,
      FDQ_K_WEL       = 4'h7,
      FDQ_K_FAIL_CLR  = 4'h8,
      FDQ_K_BOOT      = 4'h9,
      FDQ_K_BANK_RD   = 4'ha,
      FDQ_K_BANK_WR   = 4'hb,
      FDQ_K_BANK_ACC  = 4'hc,
      FDQ_K_LEARN     = 4'hd
   } fdq_kind_t;

   typedef enum logic [1:0] {
      FDQ_AM_NONE = 2'h0,
      FDQ_AM_A32  = 2'h1,
      FDQ_AM_FLAG = 2'h2
   } fdq_amode_t;

   typedef struct packed {
      logic       known;
      fdq_amode_t amode;
      logic       quad_addr;
      fdq_kind_t  kind;
   } fdq_dec_t;

   // one decoded command as handed to the array side
   typedef struct packed {
      logic [7:0]  opcode;
      fdq_kind_t   kind;
      logic        a32;
      logic [31:0] addr;
   } fdq_cmd_t;

   // gray coded along instruction, address, data, done
   typedef enum logic [1:0] {
      FDQ_ST_INSTR = 2'h0,
      FDQ_ST_ADDR  = 2'h1,
      FDQ_ST_DATA  = 2'h3,
      FDQ_ST_DONE  = 2'h2
   } fdq_state_t;

endpackage : fdq_pkg

// ---- rtl/fdq_cmd_decoder.sv ----
// dual die serial flash instruction and address decoder
// assumes: host drives sck only while cs_n is low, mode 0 framing,
// array access and status semantics sit outside and consume die_cmd
module fdq_cmd_decoder (
   input  wire logic                  sys_clk,
   input  wire logic                  rst_b,
   input  wire logic                  sck,
   input  wire logic                  cs_n,
   input  wire logic [7:0]            io_in,
   output logic [7:0]                 io_out,
   output logic [7:0]                 io_oe,
   output logic [1:0]                 die_cmd_valid,
   output fdq_pkg::fdq_cmd_t [1:0]    die_cmd,
   output logic [1:0][7:0]            bank_reg
);

   // =====================================================================
   // opcode table
   // =====================================================================
   function automatic fdq_pkg::fdq_dec_t decode_op(input logic [7:0] op);
      fdq_pkg::fdq_dec_t d;
      d = '{known: 1'b1, amode: fdq_pkg::FDQ_AM_NONE, quad_addr: 1'b0,
            kind: fdq_pkg::FDQ_K_NONE};
      case (op)
         fdq_pkg::OP_FAST_READ_A32, fdq_pkg::OP_PLAIN_READ_A32: begin
            d.amode = fdq_pkg::FDQ_AM_A32;
            d.kind  = fdq_pkg::FDQ_K_READ;
         end
         fdq_pkg::OP_QUAD_IO_READ_A32: begin
            d.amode     = fdq_pkg::FDQ_AM_A32;
            d.quad_addr = 1'b1;
            d.kind      = fdq_pkg::FDQ_K_READ;
         end
         fdq_pkg::OP_QUAD_OUT_READ_A32: begin
            d.amode = fdq_pkg::FDQ_AM_A32;
            d.kind  = fdq_pkg::FDQ_K_READ;
         end
         fdq_pkg::OP_DDR_QUAD_IO_READ_A32: begin
            d.amode     = fdq_pkg::FDQ_AM_A32;
            d.quad_addr = 1'b1;
            d.kind      = fdq_pkg::FDQ_K_READ;
         end
         fdq_pkg::OP_PAGE_PROG_A32, fdq_pkg::OP_QUAD_PAGE_PROG_A32: begin
            d.amode = fdq_pkg::FDQ_AM_A32;
            d.kind  = fdq_pkg::FDQ_K_PROG;
         end
         fdq_pkg::OP_SECTOR_ERASE_A32: begin
            d.amode = fdq_pkg::FDQ_AM_A32;
            d.kind  = fdq_pkg::FDQ_K_ERASE;
         end
         fdq_pkg::OP_PLAIN_READ_LEGACY, fdq_pkg::OP_FAST_READ_LEGACY,
         fdq_pkg::OP_QUAD_OUT_READ_LEGACY: begin
            d.amode = fdq_pkg::FDQ_AM_FLAG;
            d.kind  = fdq_pkg::FDQ_K_READ;
         end
         fdq_pkg::OP_QUAD_IO_READ_LEGACY, fdq_pkg::OP_DDR_QUAD_IO_READ_LEGACY: begin
            d.amode     = fdq_pkg::FDQ_AM_FLAG;
            d.quad_addr = 1'b1;
            d.kind      = fdq_pkg::FDQ_K_READ;
         end
         fdq_pkg::OP_PAGE_PROG_LEGACY, fdq_pkg::OP_QUAD_PAGE_PROG_LEGACY: begin
            d.amode = fdq_pkg::FDQ_AM_FLAG;
            d.kind  = fdq_pkg::FDQ_K_PROG;
         end
         fdq_pkg::OP_SECTOR_ERASE_LEGACY: begin
            d.amode = fdq_pkg::FDQ_AM_FLAG;
            d.kind  = fdq_pkg::FDQ_K_ERASE;
         end
         fdq_pkg::OP_MAKER_SIGNATURE_READ, fdq_pkg::OP_IDENTIFIER_READ,
         fdq_pkg::OP_SIGNATURE_READ, fdq_pkg::OP_PARAM_TABLE_READ:
            d.kind = fdq_pkg::FDQ_K_ID;
         fdq_pkg::OP_STATUS1_READ, fdq_pkg::OP_STATUS2_READ,
         fdq_pkg::OP_CONFIG1_READ:
            d.kind = fdq_pkg::FDQ_K_REG_RD;
         fdq_pkg::OP_REG_WRITE:
            d.kind = fdq_pkg::FDQ_K_REG_WR;
         fdq_pkg::OP_WRITE_DISABLE, fdq_pkg::OP_WRITE_ENABLE:
            d.kind = fdq_pkg::FDQ_K_WEL;
         fdq_pkg::OP_FAIL_CLEAR:
            d.kind = fdq_pkg::FDQ_K_FAIL_CLR;
         fdq_pkg::OP_BOOT_REG_READ, fdq_pkg::OP_BOOT_REG_WRITE:
            d.kind = fdq_pkg::FDQ_K_BOOT;
         fdq_pkg::OP_BANK_REG_READ:
            d.kind = fdq_pkg::FDQ_K_BANK_RD;
         fdq_pkg::OP_BANK_REG_WRITE:
            d.kind = fdq_pkg::FDQ_K_BANK_WR;
         fdq_pkg::OP_BANK_REG_LEGACY:
            d.kind = fdq_pkg::FDQ_K_BANK_ACC;
         fdq_pkg::OP_LEARN_PATTERN_READ, fdq_pkg::OP_LEARN_PATTERN_NV_PROG,
         fdq_pkg::OP_LEARN_PATTERN_VOL_WRITE:
            d.kind = fdq_pkg::FDQ_K_LEARN;
         default:
            d.known = 1'b0;
      endcase
      return d;
   endfunction : decode_op

   // =====================================================================
   // reset release on the system clock
   // =====================================================================
   logic rst_s1_r;
   logic rst_sync_b_r;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_s1_r     <= 1'b0;
         rst_sync_b_r <= 1'b0;
      end else begin
         rst_s1_r     <= 1'b1;
         rst_sync_b_r <= rst_s1_r;
      end
   end

   // link decode and output logic is cleared whenever select is high, so every frame restarts
   // decode from the instruction byte regardless of how the last one ended
   logic link_rst_b;
   assign link_rst_b = rst_b & ~cs_n;

   logic [1:0] so_r;
   logic [1:0] so_oe_r;

   assign io_out = {2'h0, so_r[1], 1'h0, 2'h0, so_r[0], 1'h0};
   assign io_oe  = {2'h0, so_oe_r[1], 1'h0, 2'h0, so_oe_r[0], 1'h0};

   // =====================================================================
   // one decoder per die, each on its own four lanes
   // =====================================================================
   for (genvar d = 0; d < fdq_pkg::NUM_DIES; d++) begin : g_die
      localparam int LO = d * fdq_pkg::LANES_PER_DIE;

      // ---------------- link side ----------------
      logic [3:0]               nib;
      logic                     si;
      logic [7:0]               bank_s1_r;
      logic [7:0]               bank_s2_r;
      fdq_pkg::fdq_state_t      state_r;
      logic [5:0]               cnt_r;
      logic [7:0]               instr_r;
      logic [7:0]               op_r;
      fdq_pkg::fdq_dec_t        dec_r;
      logic                     a32_r;
      logic [31:0]              addr_r;
      logic [7:0]               out_sr_r;
      logic [7:0]               wr_sr_r;
      fdq_pkg::fdq_cmd_t        hold_r;
      logic                     cmd_tog_r;
      logic [7:0]               bw_byte_r;
      logic                     bw_tog_r;
      fdq_pkg::fdq_dec_t        dec_now;
      logic [7:0]               op_now;
      logic [5:0]               step;
      logic [31:0]              addr_nxt;
      logic [5:0]               cnt_nxt;
      logic [31:0]              addr_full;

      assign nib = io_in[LO+3:LO];
      assign si  = io_in[LO];

      // bank value is quasi static; two stages on sck are enough because
      // the instruction byte supplies edges long before it is used
      always_ff @(posedge sck or negedge link_rst_b) begin
         if (!link_rst_b) begin
            bank_s1_r <= fdq_pkg::BANK_RESET_VAL;
            bank_s2_r <= fdq_pkg::BANK_RESET_VAL;
         end else begin
            bank_s1_r <= bank_reg[d];
            bank_s2_r <= bank_s1_r;
         end
      end

      assign op_now   = {instr_r[6:0], si};
      assign dec_now  = decode_op(op_now);
      assign step     = dec_r.quad_addr ? 6'h04 : 6'h01;
      assign addr_nxt = dec_r.quad_addr ? {addr_r[27:0], nib} : {addr_r[30:0], si};
      assign cnt_nxt  = cnt_r + step;
      // bank bits 1:0, zero extended, supply the top byte only for 24 bit addresses
      assign addr_full = a32_r ? addr_nxt
                               : {6'h00, bank_s2_r[fdq_pkg::BANK_SEL_MSB:0],
                                  addr_nxt[23:0]};

      always_ff @(posedge sck or negedge link_rst_b) begin
         if (!link_rst_b) begin
            state_r  <= fdq_pkg::FDQ_ST_INSTR;
            cnt_r    <= 6'h00;
            instr_r  <= 8'h00;
            op_r     <= 8'h00;
            dec_r    <= '0;
            a32_r    <= 1'b0;
            addr_r   <= 32'h0000_0000;
            out_sr_r <= 8'h00;
            wr_sr_r  <= 8'h00;
         end else begin
            case (state_r)
               fdq_pkg::FDQ_ST_INSTR: begin
                  instr_r <= op_now;
                  cnt_r   <= cnt_r + 6'h01;
                  if (cnt_r[2:0] == fdq_pkg::INSTR_LAST_BIT) begin
                     op_r  <= op_now;
                     dec_r <= dec_now;
                     cnt_r <= 6'h00;
                     a32_r <= (dec_now.amode == fdq_pkg::FDQ_AM_A32) ||
                              bank_s2_r[fdq_pkg::BANK_EXT_BIT];
                     out_sr_r <= bank_s2_r;
                     if (!dec_now.known)
                        state_r <= fdq_pkg::FDQ_ST_DONE;
                     else if (dec_now.amode != fdq_pkg::FDQ_AM_NONE)
                        state_r <= fdq_pkg::FDQ_ST_ADDR;
                     else if (dec_now.kind == fdq_pkg::FDQ_K_BANK_RD ||
                              dec_now.kind == fdq_pkg::FDQ_K_BANK_WR)
                        state_r <= fdq_pkg::FDQ_ST_DATA;
                     else
                        state_r <= fdq_pkg::FDQ_ST_DONE;
                  end
               end
               fdq_pkg::FDQ_ST_ADDR: begin
                  addr_r <= addr_nxt;
                  cnt_r  <= cnt_nxt;
                  if (cnt_nxt == (a32_r ? fdq_pkg::ADDR_BITS_A32
                                        : fdq_pkg::ADDR_BITS_A24)) begin
                     addr_r  <= addr_full;
                     state_r <= fdq_pkg::FDQ_ST_DONE;
                  end
               end
               fdq_pkg::FDQ_ST_DATA: begin
                  // bank read repeats the byte for as long as select stays low
                  out_sr_r <= {out_sr_r[6:0], out_sr_r[7]};
                  wr_sr_r  <= {wr_sr_r[6:0], si};
                  cnt_r    <= cnt_r + 6'h01;
                  if (dec_r.kind == fdq_pkg::FDQ_K_BANK_WR &&
                      cnt_r[2:0] == fdq_pkg::INSTR_LAST_BIT)
                     state_r <= fdq_pkg::FDQ_ST_DONE;
               end
               default: state_r <= fdq_pkg::FDQ_ST_DONE;
            endcase
         end
      end

      // hand-over words; toggles must survive the select reset, so they
      // reset only with the device reset and sit on the link clock
      always_ff @(posedge sck or negedge rst_b) begin
         if (!rst_b) begin
            hold_r    <= '0;
            cmd_tog_r <= 1'b0;
            bw_byte_r <= fdq_pkg::BANK_RESET_VAL;
            bw_tog_r  <= 1'b0;
         end else if (!cs_n) begin
            if (state_r == fdq_pkg::FDQ_ST_INSTR &&
                cnt_r[2:0] == fdq_pkg::INSTR_LAST_BIT && dec_now.known &&
                dec_now.amode == fdq_pkg::FDQ_AM_NONE) begin
               hold_r    <= '{opcode: op_now, kind: dec_now.kind, a32: 1'b0,
                              addr: 32'h0000_0000};
               cmd_tog_r <= ~cmd_tog_r;
            end else if (state_r == fdq_pkg::FDQ_ST_ADDR &&
                         cnt_nxt == (a32_r ? fdq_pkg::ADDR_BITS_A32
                                           : fdq_pkg::ADDR_BITS_A24)) begin
               hold_r    <= '{opcode: op_r, kind: dec_r.kind, a32: a32_r,
                              addr: addr_full};
               cmd_tog_r <= ~cmd_tog_r;
            end
            if (state_r == fdq_pkg::FDQ_ST_DATA &&
                dec_r.kind == fdq_pkg::FDQ_K_BANK_WR &&
                cnt_r[2:0] == fdq_pkg::INSTR_LAST_BIT) begin
               bw_byte_r <= {wr_sr_r[6:0], si};
               bw_tog_r  <= ~bw_tog_r;
            end
         end
      end

      // output lane changes on the falling edge so the host samples it
      // half a period later on the rising edge
      always_ff @(negedge sck or negedge link_rst_b) begin
         if (!link_rst_b) begin
            so_r[d]    <= 1'b0;
            so_oe_r[d] <= 1'b0;
         end else begin
            so_r[d]    <= out_sr_r[7];
            so_oe_r[d] <= (state_r == fdq_pkg::FDQ_ST_DATA) &&
                          (dec_r.kind == fdq_pkg::FDQ_K_BANK_RD);
         end
      end

      // ---------------- system side ----------------
      logic [2:0]               cmd_sync_r;
      logic [2:0]               bw_sync_r;
      logic [7:0]               bank_r;
      logic                     valid_r;
      fdq_pkg::fdq_cmd_t        cmd_r;

      always_ff @(posedge sys_clk or negedge rst_sync_b_r) begin
         if (!rst_sync_b_r) begin
            cmd_sync_r <= 3'h0;
            bw_sync_r  <= 3'h0;
         end else begin
            cmd_sync_r <= {cmd_sync_r[1:0], cmd_tog_r};
            bw_sync_r  <= {bw_sync_r[1:0], bw_tog_r};
         end
      end

      // only a bank write command changes the bank register; reads leave it
      always_ff @(posedge sys_clk or negedge rst_sync_b_r) begin
         if (!rst_sync_b_r)
            bank_r <= fdq_pkg::BANK_RESET_VAL;
         else if (bw_sync_r[2] != bw_sync_r[1])
            bank_r <= bw_byte_r;
      end

      always_ff @(posedge sys_clk or negedge rst_sync_b_r) begin
         if (!rst_sync_b_r) begin
            valid_r <= 1'b0;
            cmd_r   <= '0;
         end else begin
            valid_r <= cmd_sync_r[2] != cmd_sync_r[1];
            if (cmd_sync_r[2] != cmd_sync_r[1])
               cmd_r <= hold_r;
         end
      end

      assign die_cmd_valid[d] = valid_r;
      assign die_cmd[d]       = cmd_r;
      assign bank_reg[d]      = bank_r;
   end

endmodule : fdq_cmd_decoder

// ---- tb/fdq_cmd_decoder_assertions.sv ----
// port level checks for the dual die command decoder
// assumes both dies always see identical frames from the host
module fdq_dec_chk (
   input wire logic                  sys_clk,
   input wire logic                  rst_b,
   input wire logic                  sck,
   input wire logic                  cs_n,
   input wire logic [7:0]            io_in,
   input wire logic [7:0]            io_out,
   input wire logic [7:0]            io_oe,
   input wire logic [1:0]            die_cmd_valid,
   input wire fdq_pkg::fdq_cmd_t [1:0] die_cmd,
   input wire logic [1:0][7:0]       bank_reg
);
   timeunit 1ns;
   timeprecision 100ps;
   // ==========
   // properties
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   logic       v;
   logic       leg;
   logic [7:0] op;
   assign v   = die_cmd_valid[0];
   assign op  = die_cmd[0].opcode;
   assign leg = op inside {8'h03, 8'h0b, 8'h6b, 8'heb, 8'hed, 8'h02, 8'h32, 8'hd8};
   a_bank_reset: assert property (disable iff (1'b0) !rst_b |-> bank_reg == 16'h0000)
      else $error("bank register not cleared in reset");
   a_dies_agree: assert property (die_cmd_valid[1] == v && (!v || die_cmd[1] == die_cmd[0]))
      else $error("dies disagree on a command");
   a_one_pulse: assert property (v |=> !v)
      else $error("command pulse longer than one cycle");
   a_fixed_read: assert property (v && op inside {8'h0c, 8'h13, 8'hec} |-> die_cmd[0].a32)
      else $error("fixed width read not 32 bit");
   a_fixed_a32: assert property (v && op inside {8'h6c, 8'hee} |-> die_cmd[0].a32)
      else $error("fixed width quad read not 32 bit");
   a_fixed_prog: assert property (v && op inside {8'h12, 8'h34, 8'hdc} |-> die_cmd[0].a32)
      else $error("fixed width program or erase not 32 bit");
   a_legacy_width: assert property (v && leg |-> die_cmd[0].a32 == bank_reg[0][7])
      else $error("legacy width does not follow the flag");
   a_bank_upper: assert property (v && leg && !die_cmd[0].a32
      |-> die_cmd[0].addr[31:24] == {6'h00, bank_reg[0][1:0]})
      else $error("upper address byte not from bank");
   a_bank_keeps: assert property (v && op != 8'h17 |=> $stable(bank_reg))
      else $error("bank register changed by another command");
   a_oe_lanes: assert property ((io_oe & 8'hdd) == 8'h00 && io_oe[1] == io_oe[5])
      else $error("output enable on wrong lanes");
   a_oe_release: assert property (cs_n [*2] |-> io_oe == 8'h00)
      else $error("lanes driven while deselected");
   a_kind_known: assert property (v |-> die_cmd[0].kind != fdq_pkg::FDQ_K_NONE)
      else $error("pulse for an unknown opcode");
   c_ext_cmd: cover property (v && leg && die_cmd[0].a32);
   c_bank_read: cover property (io_oe[1]);
   c_bank_top: cover property (bank_reg[0][1:0] == 2'h3);
endmodule : fdq_dec_chk

bind fdq_cmd_decoder fdq_dec_chk fdq_dec_chk_inst (.sys_clk(sys_clk), .rst_b(rst_b),
   .sck(sck), .cs_n(cs_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
   .die_cmd_valid(die_cmd_valid), .die_cmd(die_cmd), .bank_reg(bank_reg));

// ---- tb/fdq_host_model.sv ----
// host controller model: sck, shared select and both lane groups
// assumes mode 0 framing, sck rests low between frames
module fdq_host_model (
   output logic            sck,
   output logic            cs_n,
   output logic [7:0]      io_in,
   input  wire logic [7:0] io_out
);
   timeunit 1ns;
   timeprecision 100ps;
   // ==========
   // frame driver
   localparam int HALF = 15;
   logic [1:0][7:0] rd;
   // select starts low so the falling device reset also clears the link side
   initial begin
      sck   = 1'b0;
      cs_n  = 1'b0;
      io_in = 8'h5a;
      #2 cs_n = 1'b1;
   end
   // undriven lanes toggle so a stale value never looks valid
   task automatic put(input logic [3:0] v, input bit q);
      io_in = q ? {v, v} : {~io_in[7:5], v[0], ~io_in[3:1], v[0]};
      #HALF sck = 1'b1;
      rd = {rd[1][6:0], io_out[5], rd[0][6:0], io_out[1]};
      #HALF sck = 1'b0;
   endtask : put
   task automatic frame(input logic [7:0] op, input logic [31:0] a, input int na,
                        input bit q, input logic [7:0] d, input int nd);
      cs_n = 1'b0;
      for (int i = 7; i >= 0; i--) put({3'h0, op[i]}, 1'b0);
      for (int i = na - 1; i >= 0; i -= (q ? 4 : 1))
         put(q ? a[i -: 4] : {3'h0, a[i]}, q);
      for (int i = nd - 1; i >= 0; i--) put({3'h0, d[i]}, 1'b0);
      cs_n  = 1'b1;
      io_in = ~io_in;
      #(2 * HALF);
   endtask : frame
endmodule : fdq_host_model

// ---- tb/tb.sv ----
// self-checking bench for the dual die command decoder
// assumes fdq_host_model drives the link and the checker is bound
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   // ==========
   // harness
   logic                    sys_clk;
   logic                    rst_b;
   logic                    sck;
   logic                    cs_n;
   logic [7:0]              io_in;
   logic [7:0]              io_out;
   logic [7:0]              io_oe;
   logic [1:0]              die_cmd_valid;
   fdq_pkg::fdq_cmd_t [1:0] die_cmd;
   fdq_pkg::fdq_cmd_t [1:0] got;
   logic [1:0][7:0]         bank_reg;
   logic [7:0]              bank_m;
   logic [7:0]              op;
   int                      n_fail;
   int                      num_checks;
   int                      seen;
   logic [7:0] ops [35] = '{8'h0c, 8'h13, 8'h6c, 8'h12, 8'h34, 8'hdc, 8'hec, 8'hee, 8'h03,
      8'h0b, 8'h6b, 8'h02, 8'h32, 8'hd8, 8'heb, 8'hed, 8'h90, 8'h9f, 8'hab, 8'h5a, 8'h05,
      8'h07, 8'h35, 8'h01, 8'h04, 8'h06, 8'h30, 8'h14, 8'h15, 8'h16, 8'h17, 8'hb9, 8'h41,
      8'h43, 8'h4a};
   fdq_cmd_decoder fdq_cmd_decoder_inst (.sys_clk(sys_clk), .rst_b(rst_b), .sck(sck),
      .cs_n(cs_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
      .die_cmd_valid(die_cmd_valid), .die_cmd(die_cmd), .bank_reg(bank_reg));
   fdq_host_model fdq_host_model_inst (.sck(sck), .cs_n(cs_n), .io_in(io_in), .io_out(io_out));
   always #2 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (die_cmd_valid[0] === 1'b1) begin
      seen++;
      got = die_cmd;
   end
   function automatic logic [3:0] kind_of(input logic [7:0] c);
      case (c)
         8'h0c, 8'h13, 8'h6c, 8'hec, 8'hee, 8'h03, 8'h0b, 8'h6b, 8'heb, 8'hed: return 4'h1;
         8'h12, 8'h34, 8'h02, 8'h32: return 4'h2;
         8'hdc, 8'hd8: return 4'h3;
         8'h90, 8'h9f, 8'hab, 8'h5a: return 4'h4;
         8'h05, 8'h07, 8'h35: return 4'h5;
         8'h01: return 4'h6;
         8'h04, 8'h06: return 4'h7;
         8'h30: return 4'h8;
         8'h14, 8'h15: return 4'h9;
         8'h16: return 4'ha;
         8'h17: return 4'hb;
         8'hb9: return 4'hc;
         8'h41, 8'h43, 8'h4a: return 4'hd;
         default: return 4'h0;
      endcase
   endfunction : kind_of
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen_v);
      num_checks++;
      if (seen_v !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, seen_v);
      end
   endtask : chk
   // one whole frame, then a window wide enough for the crossing and a late pulse
   task automatic cmd(input logic [7:0] c, input logic [31:0] a, input logic [7:0] d);
      logic       w;
      logic [3:0] k;
      int         na;
      k  = kind_of(c);
      w  = c inside {8'h0c, 8'h13, 8'h6c, 8'h12, 8'h34, 8'hdc, 8'hec, 8'hee} || bank_m[7];
      na = k inside {4'h1, 4'h2, 4'h3} ? (w ? 32 : 24) : 0;
      seen = 0;
      fdq_host_model_inst.frame(c, a, na, c inside {8'hec, 8'hee, 8'heb, 8'hed}, d, na ? 0 : 8);
      repeat (12) @(posedge sys_clk);
      #1;
      if (k == 4'hb) bank_m = d;
      chk("pulse count", k != 4'h0, seen);
      chk("bank", {bank_m, bank_m}, bank_reg);
      if (k == 4'ha) chk("bank read", {bank_m, bank_m}, fdq_host_model_inst.rd);
      for (int j = 0; j < 2 && k != 4'h0; j++) begin
         chk("opcode", c, got[j].opcode);
         chk("kind", k, got[j].kind);
         if (na > 0) chk("a32", w, got[j].a32);
         if (na > 0) chk("address", w ? a : {6'h00, bank_m[1:0], a[23:0]}, got[j].addr);
      end
   endtask : cmd
   task automatic end_of_test();
      $display("checks %0d failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_of_test
   // ==========
   // scenarios
   initial begin
      sys_clk = 1'b0;
      rst_b = 1'b1;
      n_fail = 0;
      num_checks = 0;
      seen = 0;
      bank_m = 8'h00;
      void'($urandom(32'h6528));
      // a real falling edge, so every asynchronously reset flop sees it
      #1 rst_b = 1'b0;
      repeat (3) @(posedge sys_clk);
      #1 rst_b = 1'b1;
      repeat (3) @(posedge sys_clk);
      #1 chk("bank after reset", 16'h0000, bank_reg);
      for (int p = 0; p < 2; p++) begin
         cmd(8'h17, 32'h0, {p[0], 5'h00, 2'($urandom)});
         foreach (ops[i]) cmd(ops[i], $urandom, ops[i] == 8'h17 ? bank_m : 8'($urandom));
      end
      for (int b = 0; b < 4; b++) begin
         cmd(8'h17, 32'h0, 8'(b));
         cmd(8'h03, b == 3 ? 32'hffffff : 32'h0, 8'h00);
      end
      repeat (4) begin
         do op = 8'($urandom); while (kind_of(op) != 4'h0);
         cmd(op, $urandom, 8'($urandom));
         cmd(8'h0b, $urandom, 8'h00);
      end
      cmd(8'h17, 32'h0, 8'h83);
      @(posedge sys_clk) #1 rst_b = 1'b0;
      repeat (3) @(posedge sys_clk);
      #1 rst_b = 1'b1;
      bank_m = 8'h00;
      repeat (3) @(posedge sys_clk);
      cmd(8'h0b, $urandom, 8'h00);
      end_of_test();
   end
   initial begin
      #300us;
      n_fail++;
      end_of_test();
   end
endmodule : tb
